//--- hdl/frame_if.sv
/*
  Carrier between the serial-clock shifter and the ref_clk register core.
  Assumes word and count are quasi-static while chip select is high.
*/
interface frame_if
  import line_driver_cfg_pkg::*;
#(
  parameter int FW = FRAME_BITS,
  parameter int CW = CNT_W
);
  logic [FW-1:0] word;
  logic [CW-1:0] count;
  logic          tag;

  // Tag toggles once per frame that shifted at least one bit
  modport link (output word, output count, output tag);
  modport core (input  word, input  count, input  tag);
endinterface : frame_if

//--- hdl/line_driver_cfg_pkg.sv
/*
  Shared constants of the line driver serial configuration port: frame layout,
  register addresses, reset and power-down codes, pin pull levels.
  Assumes nothing of its surroundings; imported by every design file.
*/
package line_driver_cfg_pkg;

  // Frame layout, first transmitted bit ends up in the top position
  localparam int           FRAME_BITS      = 12;
  localparam int           CNT_W           = 4;
  localparam int           ADDR_W          = 3;
  localparam int           DATA_W          = 8;
  localparam int           DIR_POS         = 11;
  localparam int           ADDR_MSB        = 10;
  localparam int           ADDR_LSB        = 8;
  localparam int           DATA_MSB        = 7;
  localparam int           DATA_LSB        = 0;
  localparam logic         DIR_WRITE       = 1'b1;

  // Bit counter values
  localparam logic [3:0]   CNT_ZERO        = 4'h0;
  localparam logic [3:0]   CNT_ONE         = 4'h1;
  localparam logic [3:0]   FRAME_LEN       = 4'hC;
  localparam logic [3:0]   CNT_OVER        = 4'hD;

  // Register map
  localparam logic [2:0]   ADDR_BIAS_AB    = 3'h3;
  localparam logic [2:0]   ADDR_BIAS_CD    = 3'h7;
  localparam logic [7:0]   BIAS_RESET      = 8'h80;
  localparam logic [7:0]   POWER_DOWN_CODE = 8'h80;
  localparam int           BOOST_DIS_BIT   = 7;
  localparam int           IQ_MSB          = 6;

  // Levels seen on undriven pins
  localparam logic         PULL_CS         = 1'b1;
  localparam logic         PULL_BOOST      = 1'b1;
  localparam logic         PULL_SCLK       = 1'b0;
  localparam logic         PULL_DATA       = 1'b0;

  // Synchroniser depth into the ref_clk domain
  localparam int           SYNC_STAGES     = 2;

endpackage : line_driver_cfg_pkg

//--- hdl/line_driver_serial_config_port.sv
/*
  Serial configuration port of a dual-port line driver: pin pulls, serial
  frame capture, the two bias registers and the boost decision.
  Assumes the serial clock is a second, unrelated clock and that the
  controller keeps chip select low for each whole frame.
*/
module line_driver_serial_config_port
  import line_driver_cfg_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                sclk,
  input  wire logic                sclk_drv,
  input  wire logic                cs_n,
  input  wire logic                cs_n_drv,
  input  wire logic                serial_data_in,
  input  wire logic                serial_data_in_drv,
  input  wire logic                boost_req,
  input  wire logic                boost_req_drv,
  output logic [DATA_W-1:0]        bias_ab,
  output logic [DATA_W-1:0]        bias_cd,
  output logic [IQ_MSB:0]          iq_code_ab,
  output logic [IQ_MSB:0]          iq_code_cd,
  output logic                     power_down_ab,
  output logic                     power_down_cd,
  output logic                     boost_active,
  output logic                     frame_ok,
  output logic                     frame_bad
);

  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_COMMIT} frame_state_e;

  // Pin levels after the internal pulls
  logic                   cs_n_pin;
  logic                   sclk_pin;
  logic                   data_pin;
  logic                   boost_pin;

  // Synchronisers into ref_clk: bit 0 chip select, bit 1 boost request
  logic [1:0]             sync1_q;
  logic [1:0]             sync2_q;
  logic                   cs_n_sync;
  logic                   boost_sync;

  frame_state_e           state_q;
  frame_state_e           state_d;
  logic [DATA_W-1:0]      bias_ab_q;
  logic [DATA_W-1:0]      bias_ab_d;
  logic [DATA_W-1:0]      bias_cd_q;
  logic [DATA_W-1:0]      bias_cd_d;
  logic                   boost_q;
  logic                   boost_d;
  logic                   ok_q;
  logic                   ok_d;
  logic                   bad_q;
  logic                   bad_d;

  // Frame fields as seen by the core
  logic                   f_write;
  logic [ADDR_W-1:0]      f_addr;
  logic [DATA_W-1:0]      f_data;
  logic                   f_full;
  logic                   f_fresh;
  logic                   seen_tag_q;
  logic                   seen_tag_d;

  frame_if #(.FW(FRAME_BITS), .CW(CNT_W)) fr ();

  // Undriven pins fall to their pull level
  assign cs_n_pin  = cs_n_drv           ? cs_n           : PULL_CS;
  assign boost_pin = boost_req_drv      ? boost_req      : PULL_BOOST;
  assign data_pin  = serial_data_in_drv ? serial_data_in : PULL_DATA;
  // A released clock pin sits low, which simply means no edges
  assign sclk_pin  = sclk_drv ? sclk : PULL_SCLK;

  serial_frame_shifter u_shifter (
    .sclk           (sclk_pin),
    .rst            (rst),
    .cs_n           (cs_n_pin),
    .serial_data_in (data_pin),
    .fr             (fr.link)
  );

  // Two-stage synchronisers; only sync2_q feeds any logic
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= {PULL_BOOST, PULL_CS};
      sync2_q <= {PULL_BOOST, PULL_CS};
    end
    else
    begin
      sync1_q <= {boost_pin, cs_n_pin};
      sync2_q <= sync1_q;
    end
  end

  assign cs_n_sync  = sync2_q[0];
  assign boost_sync = sync2_q[1];

  // Field split of the captured word
  assign f_write = fr.word[DIR_POS];
  assign f_addr  = fr.word[ADDR_MSB:ADDR_LSB];
  assign f_data  = fr.word[DATA_MSB:DATA_LSB];
  // Word and count outlive the frame; without the tag a select pulse with
  // no clock edges would commit the previous frame a second time.
  assign f_fresh = (fr.tag != seen_tag_q);
  assign f_full  = (fr.count == FRAME_LEN) && f_fresh;

  // Frame sequencing and register update. The word is only read in
  // ST_COMMIT, three ref_clk edges after chip select rose, when the
  // serial clock has stopped and the word is stable.
  always_comb
  begin
    state_d   = state_q;
    bias_ab_d = bias_ab_q;
    bias_cd_d = bias_cd_q;
    ok_d      = 1'b0;
    bad_d     = 1'b0;
    seen_tag_d = seen_tag_q;
    case (state_q)
      ST_IDLE:
      begin
        if (!cs_n_sync)
          state_d = ST_FRAME;
      end
      ST_FRAME:
      begin
        if (cs_n_sync)
          state_d = ST_COMMIT;
      end
      ST_COMMIT:
      begin
        state_d = ST_IDLE;
        // Remember this frame so it is never committed twice
        seen_tag_d = fr.tag;
        if (!f_full)
          bad_d = 1'b1;
        else
        begin
          ok_d = 1'b1;
          // Reads change nothing; there is no data-out pin
          if (f_write == DIR_WRITE)
          begin
            if (f_addr == ADDR_BIAS_AB)
              bias_ab_d = f_data;
            if (f_addr == ADDR_BIAS_CD)
              bias_cd_d = f_data;
          end
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Registers come up at the power-down code, i.e. disable mode
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q   <= ST_IDLE;
      bias_ab_q <= BIAS_RESET;
      bias_cd_q <= BIAS_RESET;
      ok_q      <= 1'b0;
      bad_q     <= 1'b0;
      seen_tag_q <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      bias_ab_q <= bias_ab_d;
      bias_cd_q <= bias_cd_d;
      ok_q      <= ok_d;
      bad_q     <= bad_d;
      seen_tag_q <= seen_tag_d;
    end
  end

  // Boost needs the request and at least one port with boost allowed
  always_comb
  begin
    boost_d = boost_sync &&
              (!bias_ab_q[BOOST_DIS_BIT] || !bias_cd_q[BOOST_DIS_BIT]);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      boost_q <= 1'b0;
    else
      boost_q <= boost_d;
  end

  // Outputs; power-down is the exact top-bit-only code
  assign bias_ab       = bias_ab_q;
  assign bias_cd       = bias_cd_q;
  assign iq_code_ab    = bias_ab_q[IQ_MSB:0];
  assign iq_code_cd    = bias_cd_q[IQ_MSB:0];
  assign power_down_ab = (bias_ab_q == POWER_DOWN_CODE);
  assign power_down_cd = (bias_cd_q == POWER_DOWN_CODE);
  assign boost_active  = boost_q;
  assign frame_ok      = ok_q;
  assign frame_bad     = bad_q;

  // Checks, all in the ref_clk domain
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  reset_disabled_a: assert property (
    $fell(rst) |-> (bias_ab_q == BIAS_RESET) && (bias_cd_q == BIAS_RESET) && power_down_ab && power_down_cd)
    else $error("ports not in disable mode after reset");

  short_frame_a: assert property (
    (state_q == ST_COMMIT) && !f_full |=> $stable(bias_ab_q) && $stable(bias_cd_q) && frame_bad)
    else $error("incomplete frame changed a register");

  read_frame_a: assert property (
    (state_q == ST_COMMIT) && f_full && !f_write |=> $stable(bias_ab_q) && $stable(bias_cd_q) && frame_ok)
    else $error("read frame changed a register");

  write_ab_a: assert property (
    (state_q == ST_COMMIT) && f_full && f_write && (f_addr == ADDR_BIAS_AB)
    |=> (bias_ab_q == $past(f_data)) && $stable(bias_cd_q))
    else $error("write to port AB bias not stored");

  write_cd_a: assert property (
    (state_q == ST_COMMIT) && f_full && f_write && (f_addr == ADDR_BIAS_CD)
    |=> (bias_cd_q == $past(f_data)) && $stable(bias_ab_q))
    else $error("write to port CD bias not stored");

  other_addr_a: assert property (
    (state_q == ST_COMMIT) && (f_addr != ADDR_BIAS_AB) && (f_addr != ADDR_BIAS_CD)
    |=> $stable(bias_ab_q) && $stable(bias_cd_q))
    else $error("unmapped address changed a register");

  commit_only_a: assert property (
    !$stable(bias_ab_q) || !$stable(bias_cd_q) |-> $past(state_q) == ST_COMMIT)
    else $error("register changed outside a frame end");

  cs_gate_a: assert property (
    (state_q == ST_IDLE) && cs_n_sync |=> state_q == ST_IDLE)
    else $error("frame started with chip select high");

  cs_pull_a: assert property (
    !cs_n_drv [*3] |-> cs_n_sync)
    else $error("undriven chip select not read high");

  boost_rule_a: assert property (
    ##1 boost_active == ($past(boost_sync) &&
      (!$past(bias_ab_q[BOOST_DIS_BIT]) || !$past(bias_cd_q[BOOST_DIS_BIT]))))
    else $error("boost decision wrong");

  power_down_a: assert property (
    (state_q == ST_COMMIT) && f_full && f_write && (f_addr == ADDR_BIAS_AB) && (f_data == POWER_DOWN_CODE)
    |=> power_down_ab && (iq_code_ab == '0) ##1 (!boost_active || !$past(bias_cd_q[BOOST_DIS_BIT])))
    else $error("power-down code did not power the port down");

  // Boost may legally stay on after this write while port CD still allows it
  stale_frame_a: assert property (
    (state_q == ST_COMMIT) && !f_fresh |=> frame_bad && $stable(bias_ab_q) && $stable(bias_cd_q))
    else $error("frame without fresh bits was not refused");

  idle_quiet_a: assert property (
    (state_q == ST_IDLE) |=> !frame_ok && !frame_bad)
    else $error("frame reported without a chip select cycle");

  frame_hold_a: assert property (
    (state_q == ST_FRAME) && !cs_n_sync |=> state_q == ST_FRAME)
    else $error("frame left while chip select low");

  commit_pulse_a: assert property (
    (state_q == ST_FRAME) && cs_n_sync |=> ##1 (frame_ok ^ frame_bad) ##1 !(frame_ok || frame_bad))
    else $error("frame end not reported once");

  // Main scenarios
  cover_write_ab_c: cover property (
    (state_q == ST_COMMIT) && f_full && f_write && (f_addr == ADDR_BIAS_AB));
  cover_write_cd_c: cover property (
    (state_q == ST_COMMIT) && f_full && f_write && (f_addr == ADDR_BIAS_CD));
  cover_read_c:     cover property ((state_q == ST_COMMIT) && f_full && !f_write);
  cover_bad_c:      cover property (frame_bad);
  cover_boost_c:    cover property ($rose(boost_active));

endmodule : line_driver_serial_config_port

//--- hdl/serial_frame_shifter.sv
/*
  Link-side shifter, clocked by the controller's serial clock.
  Assumes the serial clock stands still while chip select is high, so the
  captured word and bit count can be read from the ref_clk side then.
*/
module serial_frame_shifter
  import line_driver_cfg_pkg::*;
(
  input  wire logic sclk,
  input  wire logic rst,
  input  wire logic cs_n,
  input  wire logic serial_data_in,
  frame_if.link     fr
);

  logic             start_q;
  logic             start_d;
  logic [FRAME_BITS-1:0] word_q;
  logic [FRAME_BITS-1:0] word_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             tag_q;
  logic             tag_d;

  // Next frame state; a high chip select freezes everything
  always_comb
  begin
    start_d = start_q;
    word_d  = word_q;
    cnt_d   = cnt_q;
    tag_d   = tag_q;
    if (cs_n)
    begin
      start_d = start_q;
    end
    else if (start_q)
    begin
      // First bit of a fresh frame restarts the count
      word_d  = {{(FRAME_BITS-1){1'b0}}, serial_data_in};
      cnt_d   = CNT_ONE;
      start_d = 1'b0;
      // Marks the word as new, so a select pulse without clocks is not replayed
      tag_d   = ~tag_q;
    end
    else
    begin
      word_d = {word_q[FRAME_BITS-2:0], serial_data_in};
      // Saturate above twelve so an overlong frame stays invalid
      cnt_d  = (cnt_q == CNT_OVER) ? CNT_OVER : cnt_q + CNT_ONE;
    end
  end

  // Chip select high presets the start flag; no sclk edge needed to rearm
  always_ff @(posedge sclk or posedge rst or posedge cs_n)
  begin
    if (rst || cs_n)
      start_q <= 1'b1;
    else
      start_q <= start_d;
  end

  // Word and count survive chip select high so the core can read them
  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      word_q <= '0;
      cnt_q  <= CNT_ZERO;
      tag_q  <= 1'b0;
    end
    else
    begin
      word_q <= word_d;
      cnt_q  <= cnt_d;
      tag_q  <= tag_d;
    end
  end

  assign fr.word  = word_q;
  assign fr.count = cnt_q;
  assign fr.tag   = tag_q;

endmodule : serial_frame_shifter

//--- tb/serial_ctl_model.sv
/*
  Controller model for the serial configuration port: frames chip select,
  runs the serial clock inside frames or, in noise, with select high or floating, and releases the data line after.
  Assumes the bench calls one task at a time, starting on a falling ref_clk edge.
*/
module serial_ctl_model
(
  input  wire logic ref_clk,
  output logic      sclk,
  output logic      sclk_drv,
  output logic      cs_n,
  output logic      cs_n_drv,
  output logic      serial_data_in,
  output logic      serial_data_in_drv
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle: select high, clock parked low, data released to its pull-down
  initial
  begin
    sclk               = 1'b0;
    sclk_drv           = 1'b1;
    cs_n               = 1'b1;
    cs_n_drv           = 1'b1;
    serial_data_in     = 1'b0;
    serial_data_in_drv = 1'b0;
  end

  // Sends n bits first-bit-first; 13 appends one zero bit, 0 sends none
  task automatic send(input logic [11:0] w, input int n);
    logic b;
    b = 1'b0;
    @(negedge ref_clk) cs_n = 1'b0;
    #21;
    serial_data_in_drv = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      b = (i < 12) ? w[11-i] : 1'b0;
      serial_data_in = b;
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #19;
    @(negedge ref_clk) cs_n = 1'b1;
    // Inverted so a design that keeps sampling sees different data
    serial_data_in     = ~b;
    serial_data_in_drv = 1'b0;
  endtask : send

  // Clock and data activity with select high, or with select left floating
  task automatic noise(input logic cs_float);
    @(negedge ref_clk) cs_n_drv = !cs_float;
    cs_n               = !cs_float;
    serial_data_in     = 1'b1;
    serial_data_in_drv = 1'b1;
    repeat (12)
    begin
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    @(negedge ref_clk) cs_n = 1'b1;
    cs_n_drv           = 1'b1;
    serial_data_in_drv = 1'b0;
  endtask : noise
endmodule : serial_ctl_model

//--- tb/tb_top.sv
/*
  Self-checking bench for the serial configuration port.
  Assumes the controller model drives the link; the bench owns reset and boost.
*/
module tb_top
  import line_driver_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              ref_clk;
  logic              rst;
  logic              sclk;
  logic              sclk_drv;
  logic              cs_n;
  logic              cs_n_drv;
  logic              serial_data_in;
  logic              serial_data_in_drv;
  logic              boost_req;
  logic              boost_req_drv;
  logic [7:0]        bias_ab;
  logic [7:0]        bias_cd;
  logic [6:0]        iq_code_ab;
  logic [6:0]        iq_code_cd;
  logic              power_down_ab;
  logic              power_down_cd;
  logic              boost_active;
  logic              frame_ok;
  logic              frame_bad;
  logic [7:0]        exp_ab;
  logic [7:0]        exp_cd;
  int                n_errors;
  int                cmp_count;
  int                n_pulses;

  line_driver_serial_config_port line_driver_serial_config_port_inst (
    .ref_clk            (ref_clk),
    .rst                (rst),
    .sclk               (sclk),
    .sclk_drv           (sclk_drv),
    .cs_n               (cs_n),
    .cs_n_drv           (cs_n_drv),
    .serial_data_in     (serial_data_in),
    .serial_data_in_drv (serial_data_in_drv),
    .boost_req          (boost_req),
    .boost_req_drv      (boost_req_drv),
    .bias_ab            (bias_ab),
    .bias_cd            (bias_cd),
    .iq_code_ab         (iq_code_ab),
    .iq_code_cd         (iq_code_cd),
    .power_down_ab      (power_down_ab),
    .power_down_cd      (power_down_cd),
    .boost_active       (boost_active),
    .frame_ok           (frame_ok),
    .frame_bad          (frame_bad)
  );

  serial_ctl_model serial_ctl_model_inst (.ref_clk(ref_clk), .sclk(sclk), .sclk_drv(sclk_drv), .cs_n(cs_n),
    .cs_n_drv(cs_n_drv), .serial_data_in(serial_data_in), .serial_data_in_drv(serial_data_in_drv));

  // Core clock, 8 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Counts frame reports away from the launching edge, so none slips by
  always @(negedge ref_clk)
  begin
    if (frame_ok || frame_bad)
      n_pulses++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_regs();
    chk(bias_ab, exp_ab);
    chk(bias_cd, exp_cd);
    chk({1'b0, iq_code_ab}, {1'b0, exp_ab[6:0]});
    chk({1'b0, iq_code_cd}, {1'b0, exp_cd[6:0]});
    chk({7'h00, power_down_ab}, {7'h00, exp_ab == 8'h80});
    chk({7'h00, power_down_cd}, {7'h00, exp_cd == 8'h80});
  endtask : chk_regs

  // Boost passes two sync flops and a register, so four cycles is ample
  task automatic chk_boost(input logic e);
    repeat (4) @(negedge ref_clk);
    chk({7'h00, boost_active}, {7'h00, e});
  endtask : chk_boost

  // One frame; expected registers follow only complete write frames
  task automatic frame(input logic [11:0] w, input int n);
    int k;
    k = 0;
    serial_ctl_model_inst.send(w, n);
    while (frame_ok !== 1'b1 && frame_bad !== 1'b1 && k < 12)
    begin
      @(negedge ref_clk);
      k++;
    end
    chk({6'h00, frame_ok, frame_bad}, {6'h00, n == 12, n != 12});
    if (n == 12 && w[11] && w[10:8] == 3'h3)
      exp_ab = w[7:0];
    if (n == 12 && w[11] && w[10:8] == 3'h7)
      exp_cd = w[7:0];
    repeat (6) @(negedge ref_clk);
    chk_regs();
  endtask : frame

  task automatic t_reset();
    chk_regs();
    chk({7'h00, boost_active}, 8'h00);
    @(negedge ref_clk) rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk_regs();
    chk_boost(1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_boost();
    frame(12'hB1C, 12);
    chk_boost(1'b1);
    boost_req_drv = 1'b1;
    chk_boost(1'b0);
    boost_req = 1'b1;
    chk_boost(1'b1);
    frame(12'hB80, 12);
    chk_boost(1'b0);
    frame(12'hF05, 12);
    chk_boost(1'b1);
    frame(12'hF80, 12);
    chk_boost(1'b0);
    $display("test boost done");
  endtask : t_boost

  task automatic t_read_sweep();
    frame(12'hB2A, 12);
    frame(12'h333, 12);
    frame(12'h7F0, 12);
    for (int a = 0; a < 8; a++)
    begin
      frame({1'b1, a[2:0], 5'h08, a[2:0]}, 12);
    end
    $display("test read and sweep done");
  endtask : t_read_sweep

  task automatic t_bad();
    frame(12'hB55, 11);
    frame(12'hF55, 13);
    frame(12'hF6B, 1);
    frame(12'hF61, 12);
    frame(12'hB00, 0);
    $display("test bad length done");
  endtask : t_bad

  // Activity with select high or floating would write 8'hFF to port CD
  task automatic t_cs_high();
    int p0;
    p0 = n_pulses;
    serial_ctl_model_inst.noise(1'b0);
    serial_ctl_model_inst.noise(1'b1);
    repeat (8) @(negedge ref_clk);
    chk({6'h00, frame_ok, frame_bad}, 8'h00);
    chk(n_pulses[7:0], p0[7:0]);
    chk_regs();
    $display("test select high done");
  endtask : t_cs_high

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // Main sequence: reset held four cycles, then every scenario in turn
  initial
  begin
    rst           = 1'b1;
    boost_req     = 1'b0;
    boost_req_drv = 1'b0;
    exp_ab        = 8'h80;
    exp_cd        = 8'h80;
    n_errors      = 0;
    cmp_count     = 0;
    n_pulses      = 0;
    repeat (3) @(negedge ref_clk);
    t_reset();
    t_boost();
    t_read_sweep();
    t_bad();
    t_cs_high();
    conclude();
  end

  // About twenty frames of roughly one microsecond; a hang ends the run
  initial
  begin
    #100000;
    n_errors++;
    conclude();
  end
endmodule : tb_top
